// [inc/rldc_pkg.sv]
// Package for the RGBW LED dimming control block: timing counts and states.
// Assumes a 100 MHz core clock; all derived counts follow from CLK_FREQ_MHZ.
package rldc_pkg;

    // Core clock rate
    localparam int unsigned CLK_FREQ_MHZ = 100;

    // Channel count and code widths
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned DUTY_W = 11;
    localparam int unsigned AMP_W = 8;
    localparam int unsigned CODE_W = 8;

    // Full duty code: channel stays on for the whole period
    localparam logic [10:0] DUTY_FULL = 11'h400;

    // PWM step length per unit of frequency code (0x10 gives about 1.95 kHz)
    localparam int unsigned PWM_STEP_NS_PER_CODE = 30;
    localparam int unsigned PWM_STEP_CYC_PER_CODE = (PWM_STEP_NS_PER_CODE * CLK_FREQ_MHZ) / 1000;

    // Blink time base: 16.384 ms per code unit
    localparam int unsigned BLINK_TICK_US = 16384;
    localparam int unsigned BLINK_TICK_CYCLES = BLINK_TICK_US * CLK_FREQ_MHZ;

    // Protection debounce delays
    localparam int unsigned SHORT_DLY_MS = 24;
    localparam int unsigned SHORT_DLY_CYCLES = SHORT_DLY_MS * 1000 * CLK_FREQ_MHZ;
    localparam int unsigned ALL_SHORT_DLY_MS = 100;
    localparam int unsigned ALL_SHORT_DLY_CYCLES = ALL_SHORT_DLY_MS * 1000 * CLK_FREQ_MHZ;
    localparam int unsigned OPEN_DLY_MS = 24;
    localparam int unsigned OPEN_DLY_CYCLES = OPEN_DLY_MS * 1000 * CLK_FREQ_MHZ;

    // Upper bits of the target address; value is arbitrary
    localparam logic [2:0] TARGET_ADDR_HI_RST = 3'h3;

    // Supply and enable states
    typedef enum logic [1:0] {
        RLDC_LOCKOUT = 2'b00,
        RLDC_STANDBY = 2'b01,
        RLDC_ACTIVE = 2'b10
    } rldc_state_t;

endpackage

// [logic/rldc_top.sv]
// Control logic of a four-channel RGBW LED driver: standby, enables, PWM dimming,
// blinking and open/short protection debounce.
// Assumes configuration bits come from a register file on the same clock; supply,
// fault comparators and address sense arrive asynchronously.
//
// Contract
// RULE_01: Above lockout: standby, port active, LEDs off
// RULE_02: Operation starts only after global enable set
// RULE_03: Channel drives only while its enable high
// RULE_04: Direct-supply channel excluded from voltage loop
// RULE_05: Sixteen target addresses from sensed pin
// RULE_06: Per-channel 10-bit duty, 8-bit amplitude
// RULE_07: Full duty, code 0x64 gives 20 mA
// RULE_08: Full duty, code 0x01 gives 0.2 mA
// RULE_09: Frequency code 0x10 gives about 1.95 kHz
// RULE_10: Duty 0x002 at 0x10 gives 1 us
// RULE_11: Blink period code 0x20 gives 1.907 Hz
// RULE_12: Blink on-time code 0x01 gives 16 ms
// RULE_13: Channel short acted on after 24 ms
// RULE_14: All enabled channels shorted: 100 ms delay
// RULE_15: Channel open acted on after 24 ms
// RULE_16: Duty fraction is code over 1024
// RULE_17: Amplitude is 0.2 mA times code
// RULE_18: Blink period and on-time in 16.384 ms units
// RULE_19: Blink channels 1-3; fourth only when joined
// RULE_20: Delay counters restart when fault clears early
// RULE_21: Dimming timers idle when disabled
`timescale 1ns/1ps
`default_nettype none

module rldc_top
    import rldc_pkg::*;
#(
    parameter int unsigned BLINK_TICK = BLINK_TICK_CYCLES,
    parameter int unsigned CH_SHORT_DLY = SHORT_DLY_CYCLES,
    parameter int unsigned ALL_SHORT_DLY = ALL_SHORT_DLY_CYCLES,
    parameter int unsigned CH_OPEN_DLY = OPEN_DLY_CYCLES,
    parameter int unsigned CNT_W = 24
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Supply and address sense (asynchronous)
    input wire logic supply_ok_in,
    input wire logic [3:0] addr_sense_in,
    // Configuration bits
    input wire logic global_enable_in,
    input wire logic [NUM_CH-1:0] channel_on_bit_in,
    input wire logic [NUM_CH-1:0] direct_supply_anode_select_in,
    input wire logic [NUM_CH-1:0][AMP_W-1:0] analog_current_code_in,
    input wire logic [NUM_CH-1:0][DUTY_W-1:0] pwm_duty_code_in,
    input wire logic [CODE_W-1:0] pwm_frequency_code_in,
    input wire logic blink_mode_enable_in,
    input wire logic fourth_channel_blink_join_in,
    input wire logic [CODE_W-1:0] blink_period_code_in,
    input wire logic [CODE_W-1:0] blink_on_time_code_in,
    // Fault comparators (asynchronous)
    input wire logic [NUM_CH-1:0] led_short_in,
    input wire logic [NUM_CH-1:0] led_open_in,
    // Status
    output logic standby_out,
    output logic port_active_out,
    output logic [6:0] target_addr_out,
    // Channel drive
    output logic [NUM_CH-1:0] channel_drive_out,
    output logic [NUM_CH-1:0][AMP_W-1:0] current_code_out,
    output logic [NUM_CH-1:0] loop_member_out,
    // Protection flags
    output logic [NUM_CH-1:0] short_fault_out,
    output logic [NUM_CH-1:0] open_fault_out,
    output logic all_short_fault_out
);

    // Elaboration checks
    if (CNT_W > 32 || ALL_SHORT_DLY >= (64'd1 << CNT_W) || CH_SHORT_DLY >= (64'd1 << CNT_W)
        || CH_OPEN_DLY >= (64'd1 << CNT_W) || BLINK_TICK >= (64'd1 << CNT_W)) begin : g_chk_w
        $error("Delay counts do not fit the counter width");
    end
    if (BLINK_TICK < 1 || CH_SHORT_DLY < 1 || ALL_SHORT_DLY < 1 || CH_OPEN_DLY < 1) begin : g_chk_z
        $error("Delay counts must be at least one");
    end

    // Debounce step: count while fault persists, restart at zero when it clears
    function automatic logic [CNT_W-1:0] dly_step(input logic [CNT_W-1:0] cnt,
                                                  input logic cond,
                                                  input logic [CNT_W-1:0] lim);
        logic [CNT_W-1:0] res;
        res = '0;
        if (cond && cnt < lim) begin
            res = cnt + 1'b1;
        end else if (cond) begin
            res = cnt;
        end
        return res;
    endfunction

    localparam logic [CNT_W-1:0] LIM_SHORT = CNT_W'(CH_SHORT_DLY);
    localparam logic [CNT_W-1:0] LIM_ALL = CNT_W'(ALL_SHORT_DLY);
    localparam logic [CNT_W-1:0] LIM_OPEN = CNT_W'(CH_OPEN_DLY);
    localparam logic [CNT_W-1:0] LIM_TICK = CNT_W'(BLINK_TICK - 1);
    localparam logic [9:0] STEP_MUL = 10'(PWM_STEP_CYC_PER_CODE);

    // Synchroniser stages
    logic supply_meta_reg, supply_sync_reg;
    logic [3:0] addr_meta_reg, addr_sync_reg;
    logic [NUM_CH-1:0] short_meta_reg, short_sync_reg;
    logic [NUM_CH-1:0] open_meta_reg, open_sync_reg;

    // Two-flop synchronisers for asynchronous inputs
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            supply_meta_reg <= 1'b0;
            supply_sync_reg <= 1'b0;
            addr_meta_reg <= 4'h0;
            addr_sync_reg <= 4'h0;
            short_meta_reg <= '0;
            short_sync_reg <= '0;
            open_meta_reg <= '0;
            open_sync_reg <= '0;
        end else begin
            supply_meta_reg <= supply_ok_in;
            supply_sync_reg <= supply_meta_reg;
            addr_meta_reg <= addr_sense_in;
            addr_sync_reg <= addr_meta_reg;
            short_meta_reg <= led_short_in;
            short_sync_reg <= short_meta_reg;
            open_meta_reg <= led_open_in;
            open_sync_reg <= open_meta_reg;
        end
    end

    // Supply and enable state machine
    rldc_state_t state_reg, state_next;
    logic [3:0] addr_reg, addr_next;
    logic active;

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        unique case (state_reg)
            RLDC_LOCKOUT: begin
                addr_next = addr_sync_reg; // RULE_05
                if (supply_sync_reg) begin
                    state_next = RLDC_STANDBY; // RULE_01
                end
            end
            RLDC_STANDBY: begin
                if (!supply_sync_reg) begin
                    state_next = RLDC_LOCKOUT;
                end else if (global_enable_in) begin
                    state_next = RLDC_ACTIVE; // RULE_02
                end
            end
            RLDC_ACTIVE: begin
                if (!supply_sync_reg) begin
                    state_next = RLDC_LOCKOUT;
                end else if (!global_enable_in) begin
                    state_next = RLDC_STANDBY;
                end
            end
            default: state_next = RLDC_LOCKOUT;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= RLDC_LOCKOUT;
            addr_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
        end
    end

    assign active = (state_reg == RLDC_ACTIVE);

    // PWM step divider and 1024-step period counter
    logic [9:0] step_div_reg, step_div_next;
    logic [9:0] step_cnt_reg, step_cnt_next;
    logic [9:0] step_len;

    always_comb begin
        step_len = (pwm_frequency_code_in == 8'h00) ? STEP_MUL
                 : 10'(pwm_frequency_code_in * STEP_MUL); // RULE_09
        step_div_next = step_div_reg;
        step_cnt_next = step_cnt_reg;
        if (!active) begin
            step_div_next = 10'h000; // RULE_21
            step_cnt_next = 10'h000;
        end else if (step_div_reg >= step_len - 10'h001) begin
            step_div_next = 10'h000;
            step_cnt_next = step_cnt_reg + 10'h001; // RULE_16
        end else begin
            step_div_next = step_div_reg + 10'h001;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            step_div_reg <= 10'h000;
            step_cnt_reg <= 10'h000;
        end else begin
            step_div_reg <= step_div_next;
            step_cnt_reg <= step_cnt_next;
        end
    end

    // Blink tick divider and blink cycle counter
    logic [CNT_W-1:0] tick_div_reg, tick_div_next;
    logic [7:0] blink_cnt_reg, blink_cnt_next;
    logic blink_run, blink_lit;

    always_comb begin
        blink_run = active && blink_mode_enable_in && (blink_period_code_in != 8'h00);
        tick_div_next = tick_div_reg;
        blink_cnt_next = blink_cnt_reg;
        if (!blink_run) begin
            tick_div_next = '0;
            blink_cnt_next = 8'h00;
        end else if (tick_div_reg >= LIM_TICK) begin
            tick_div_next = '0; // RULE_18
            if (blink_cnt_reg >= blink_period_code_in - 8'h01) begin
                blink_cnt_next = 8'h00; // RULE_11
            end else begin
                blink_cnt_next = blink_cnt_reg + 8'h01;
            end
        end else begin
            tick_div_next = tick_div_reg + 1'b1;
        end
        // On-time longer than period leaves the channel lit throughout
        blink_lit = !blink_run || (blink_cnt_reg < blink_on_time_code_in); // RULE_12
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick_div_reg <= '0;
            blink_cnt_reg <= 8'h00;
        end else begin
            tick_div_reg <= tick_div_next;
            blink_cnt_reg <= blink_cnt_next;
        end
    end

    // Protection debounce counters
    logic [NUM_CH-1:0][CNT_W-1:0] short_cnt_reg, short_cnt_next;
    logic [NUM_CH-1:0][CNT_W-1:0] open_cnt_reg, open_cnt_next;
    logic [CNT_W-1:0] all_cnt_reg, all_cnt_next;
    logic [NUM_CH-1:0] ch_live, short_flag, open_flag;
    logic all_cond, all_flag;

    always_comb begin
        ch_live = active ? channel_on_bit_in : '0;
        all_cond = (ch_live != '0) && ((short_sync_reg & ch_live) == ch_live);
        for (int i = 0; i < NUM_CH; i++) begin
            short_cnt_next[i] = dly_step(short_cnt_reg[i], ch_live[i] && short_sync_reg[i],
                                         LIM_SHORT); // RULE_20
            open_cnt_next[i] = dly_step(open_cnt_reg[i], ch_live[i] && open_sync_reg[i],
                                        LIM_OPEN); // RULE_20
            short_flag[i] = (short_cnt_reg[i] == LIM_SHORT); // RULE_13
            open_flag[i] = (open_cnt_reg[i] == LIM_OPEN); // RULE_15
        end
        all_cnt_next = dly_step(all_cnt_reg, all_cond, LIM_ALL); // RULE_20
        all_flag = (all_cnt_reg == LIM_ALL); // RULE_14
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            short_cnt_reg <= '0;
            open_cnt_reg <= '0;
            all_cnt_reg <= '0;
        end else begin
            short_cnt_reg <= short_cnt_next;
            open_cnt_reg <= open_cnt_next;
            all_cnt_reg <= all_cnt_next;
        end
    end

    // Registered outputs
    logic standby_next, port_next, all_next;
    logic [6:0] taddr_next;
    logic [NUM_CH-1:0] drive_next, loop_next, sflag_next, oflag_next;
    logic [NUM_CH-1:0][AMP_W-1:0] amp_next;
    logic [NUM_CH-1:0] blinks;
    logic pwm_on;

    always_comb begin
        standby_next = (state_reg == RLDC_STANDBY);
        port_next = (state_reg != RLDC_LOCKOUT); // RULE_01
        taddr_next = {TARGET_ADDR_HI_RST, addr_reg}; // RULE_05
        all_next = all_flag;
        for (int i = 0; i < NUM_CH; i++) begin
            // Channels 1-3 follow blink mode; the fourth needs its join bit
            blinks[i] = blink_mode_enable_in
                        && ((i != NUM_CH - 1) || fourth_channel_blink_join_in); // RULE_19
            pwm_on = (pwm_duty_code_in[i] >= DUTY_FULL)
                     || ({1'b0, step_cnt_reg} < pwm_duty_code_in[i]); // RULE_06 RULE_10 RULE_16
            drive_next[i] = ch_live[i] && pwm_on && (!blinks[i] || blink_lit)
                            && !short_flag[i] && !open_flag[i] && !all_flag; // RULE_03
            // Amplitude code, 0.2 mA per unit, held off when channel off
            amp_next[i] = ch_live[i] ? analog_current_code_in[i]
                                     : 8'h00; // RULE_07 RULE_08 RULE_17
            loop_next[i] = ch_live[i] && !direct_supply_anode_select_in[i]; // RULE_04
            sflag_next[i] = short_flag[i];
            oflag_next[i] = open_flag[i];
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            standby_out <= 1'b0;
            port_active_out <= 1'b0;
            target_addr_out <= {TARGET_ADDR_HI_RST, 4'h0};
            channel_drive_out <= '0;
            current_code_out <= '0;
            loop_member_out <= '0;
            short_fault_out <= '0;
            open_fault_out <= '0;
            all_short_fault_out <= 1'b0;
        end else begin
            standby_out <= standby_next;
            port_active_out <= port_next;
            target_addr_out <= taddr_next;
            channel_drive_out <= drive_next;
            current_code_out <= amp_next;
            loop_member_out <= loop_next;
            short_fault_out <= sflag_next;
            open_fault_out <= oflag_next;
            all_short_fault_out <= all_next;
        end
    end

endmodule

`default_nettype wire

// [verif/rldc_top_props.sv]
// Checker for the LED dimming control: enables, standby exit and fault timing.
// Assumes the bind below and the reduced delay parameters of the bench.
`timescale 1ns/1ps
`default_nettype none
module rldc_chk
    import rldc_pkg::*;
#(
    parameter int unsigned CH_SHORT_DLY = 20,
    parameter int unsigned ALL_SHORT_DLY = 50,
    parameter int unsigned CH_OPEN_DLY = 20
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Watched inputs
    input wire logic global_enable_in,
    input wire logic [NUM_CH-1:0] channel_on_bit_in,
    input wire logic [NUM_CH-1:0] direct_supply_anode_select_in,
    input wire logic [NUM_CH-1:0][AMP_W-1:0] analog_current_code_in,
    input wire logic [NUM_CH-1:0] led_short_in,
    input wire logic [NUM_CH-1:0] led_open_in,
    // Watched outputs
    input wire logic standby_out,
    input wire logic port_active_out,
    input wire logic [NUM_CH-1:0] channel_drive_out,
    input wire logic [NUM_CH-1:0][AMP_W-1:0] current_code_out,
    input wire logic [NUM_CH-1:0] loop_member_out,
    input wire logic [NUM_CH-1:0] short_fault_out,
    input wire logic [NUM_CH-1:0] open_fault_out,
    input wire logic all_short_fault_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [31:0] srun_reg, srun_next, orun_reg, orun_next, arun_reg, arun_next;
    // Lengths of unbroken raw fault runs
    always_comb begin
        srun_next = led_short_in[1] ? srun_reg + 32'h1 : 32'h0;
        orun_next = led_open_in[0] ? orun_reg + 32'h1 : 32'h0;
        arun_next = (&led_short_in) ? arun_reg + 32'h1 : 32'h0;
    end
    // Run registers
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            srun_reg <= 32'h0;
            orun_reg <= 32'h0;
            arun_reg <= 32'h0;
        end else begin
            srun_reg <= srun_next;
            orun_reg <= orun_next;
            arun_reg <= arun_next;
        end
    end
    property p_dark; standby_out |-> channel_drive_out == '0 && current_code_out == '0; endproperty
    a_dark: assert property (p_dark) else $error("drive in standby");
    property p_port; standby_out |-> port_active_out; endproperty
    a_port: assert property (p_port) else $error("port idle in standby");
    property p_wait; standby_out && !global_enable_in && !$past(global_enable_in) |=> standby_out;
    endproperty
    a_wait: assert property (p_wait) else $error("left standby unasked");
    property p_choff; 1 |=> (channel_drive_out & ~$past(channel_on_bit_in)) == '0; endproperty
    a_choff: assert property (p_choff) else $error("disabled channel drives");
    property p_direct; 1 |=> (loop_member_out & $past(direct_supply_anode_select_in)) == '0;
    endproperty
    a_direct: assert property (p_direct) else $error("direct channel in loop");
    property p_amp;
        channel_drive_out[0] |-> current_code_out[0] == $past(analog_current_code_in[0]);
    endproperty
    a_amp: assert property (p_amp) else $error("amplitude mismatch");
    property p_sdly; $rose(short_fault_out[1]) |-> srun_reg >= CH_SHORT_DLY; endproperty
    a_sdly: assert property (p_sdly) else $error("short flag early");
    property p_odly; $rose(open_fault_out[0]) |-> orun_reg >= CH_OPEN_DLY; endproperty
    a_odly: assert property (p_odly) else $error("open flag early");
    property p_adly; $rose(all_short_fault_out) |-> arun_reg >= ALL_SHORT_DLY; endproperty
    a_adly: assert property (p_adly) else $error("all-short flag early");
    property p_clr; !led_open_in[0] [*4] |=> !open_fault_out[0]; endproperty
    a_clr: assert property (p_clr) else $error("open flag kept");
    c_run: cover property ($fell(standby_out));
    c_short: cover property ($rose(short_fault_out[1]));
    c_all: cover property ($rose(all_short_fault_out));
endmodule
bind rldc_top rldc_chk #(.CH_SHORT_DLY(CH_SHORT_DLY), .ALL_SHORT_DLY(ALL_SHORT_DLY),
    .CH_OPEN_DLY(CH_OPEN_DLY)) u_chk (.core_clk_in, .sys_rst_in, .global_enable_in,
    .channel_on_bit_in, .direct_supply_anode_select_in, .analog_current_code_in,
    .led_short_in, .led_open_in, .standby_out, .port_active_out, .channel_drive_out,
    .current_code_out, .loop_member_out, .short_fault_out, .open_fault_out,
    .all_short_fault_out);
`default_nettype wire

// [verif/rldc_host_model.sv]
// Host model: holds the configuration levels that the serial port would write.
// Assumes the caller's clock; every write after time zero lands at a falling edge.
`timescale 1ns/1ps
`default_nettype none
module rldc_host_model
    import rldc_pkg::*;
(
    // Clock
    input wire logic core_clk_in,
    // Configuration levels
    output logic global_enable_out,
    output logic [NUM_CH-1:0] channel_on_bit_out,
    output logic [NUM_CH-1:0] direct_supply_anode_select_out,
    output logic [NUM_CH-1:0][AMP_W-1:0] analog_current_code_out,
    output logic [NUM_CH-1:0][DUTY_W-1:0] pwm_duty_code_out,
    output logic [CODE_W-1:0] pwm_frequency_code_out,
    output logic blink_mode_enable_out,
    output logic fourth_channel_blink_join_out,
    output logic [CODE_W-1:0] blink_period_code_out,
    output logic [CODE_W-1:0] blink_on_time_code_out
);
    // Quiet configuration at time zero
    initial begin
        global_enable_out = 1'b0;
        channel_on_bit_out = '0;
        direct_supply_anode_select_out = '0;
        analog_current_code_out = '0;
        pwm_duty_code_out = '0;
        set_glob(1'b0, 8'h10, 1'b0, 1'b0, 8'h04, 8'h01);
    end
    // One channel's settings
    task automatic set_ch(input int i, input logic on, input logic ds, input logic [7:0] amp,
        input logic [10:0] duty);
        @(negedge core_clk_in);
        channel_on_bit_out[i] = on;
        direct_supply_anode_select_out[i] = ds;
        analog_current_code_out[i] = amp;
        pwm_duty_code_out[i] = duty;
    endtask
    // Shared settings and the global enable
    task automatic set_glob(input logic en, input logic [7:0] fq, input logic bk, input logic jn,
        input logic [7:0] per, input logic [7:0] ont);
        if ($time > 0) @(negedge core_clk_in);
        global_enable_out = en;
        pwm_frequency_code_out = fq;
        blink_mode_enable_out = bk;
        fourth_channel_blink_join_out = jn;
        blink_period_code_out = per;
        blink_on_time_code_out = ont;
    endtask
endmodule
`default_nettype wire

// [verif/rldc_top_bench.sv]
// Bench for the LED dimming control: walks enables, dimming, blinking, faults.
// Assumes the host model for configuration and reduced delay parameters.
`timescale 1ns/1ps
`default_nettype none
module rldc_top_bench;
    import rldc_pkg::*;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic supply_ok_in = 1'b1;
    logic [3:0] addr_sense_in = 4'hA;
    logic [NUM_CH-1:0] led_short_in = '0, led_open_in = '0;
    logic global_enable_in, blink_mode_enable_in, fourth_channel_blink_join_in;
    logic [NUM_CH-1:0] channel_on_bit_in, direct_supply_anode_select_in;
    logic [NUM_CH-1:0][AMP_W-1:0] analog_current_code_in, current_code_out;
    logic [NUM_CH-1:0][DUTY_W-1:0] pwm_duty_code_in;
    logic [CODE_W-1:0] pwm_frequency_code_in, blink_period_code_in, blink_on_time_code_in;
    logic standby_out, port_active_out, all_short_fault_out;
    logic [6:0] target_addr_out;
    logic [NUM_CH-1:0] channel_drive_out, loop_member_out, short_fault_out, open_fault_out;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    int hi[NUM_CH];
    int bj[3] = '{0, 1, 1};
    int bo[3] = '{1, 1, 5};
    int b0[3] = '{16, 16, 64};
    int b3[3] = '{64, 16, 64};
    // Clock, 100 MHz
    always #5 core_clk_in = ~core_clk_in;
    rldc_host_model u_host (.core_clk_in(core_clk_in), .global_enable_out(global_enable_in),
        .channel_on_bit_out(channel_on_bit_in),
        .direct_supply_anode_select_out(direct_supply_anode_select_in),
        .analog_current_code_out(analog_current_code_in), .pwm_duty_code_out(pwm_duty_code_in),
        .pwm_frequency_code_out(pwm_frequency_code_in),
        .blink_mode_enable_out(blink_mode_enable_in),
        .fourth_channel_blink_join_out(fourth_channel_blink_join_in),
        .blink_period_code_out(blink_period_code_in),
        .blink_on_time_code_out(blink_on_time_code_in));
    rldc_top #(.BLINK_TICK(16), .CH_SHORT_DLY(20), .ALL_SHORT_DLY(50), .CH_OPEN_DLY(20)) u_dut (
        .core_clk_in, .sys_rst_in, .supply_ok_in, .addr_sense_in, .global_enable_in,
        .channel_on_bit_in, .direct_supply_anode_select_in, .analog_current_code_in,
        .pwm_duty_code_in, .pwm_frequency_code_in, .blink_mode_enable_in,
        .fourth_channel_blink_join_in, .blink_period_code_in, .blink_on_time_code_in,
        .led_short_in, .led_open_in, .standby_out, .port_active_out, .target_addr_out,
        .channel_drive_out, .current_code_out, .loop_member_out, .short_fault_out,
        .open_fault_out, .all_short_fault_out);
    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Count drive-high cycles per channel over a window
    task automatic measure(input int n);
        hi = '{default: 0};
        repeat (n) begin
            @(negedge core_clk_in);
            for (int i = 0; i < NUM_CH; i++) if (channel_drive_out[i] === 1'b1) hi[i]++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 70000) begin
            n_fail++;
            give_verdict();
        end
    end
    // Main sequence
    initial begin
        wt(3);
        sys_rst_in = 1'b0;
        wt(10);
        chk("standby", 1, standby_out);
        chk("port", 1, port_active_out);
        chk("addr", {TARGET_ADDR_HI_RST, 4'hA}, target_addr_out);
        u_host.set_ch(0, 1'b1, 1'b0, 8'h64, 11'h002);
        u_host.set_ch(1, 1'b1, 1'b0, 8'h01, 11'h200);
        u_host.set_ch(2, 1'b1, 1'b1, 8'hC8, 11'h000);
        u_host.set_ch(3, 1'b0, 1'b0, 8'h10, 11'h400);
        wt(10);
        chk("held", 1, standby_out);
        chk("dark", 0, channel_drive_out);
        u_host.set_glob(1'b1, 8'h10, 1'b0, 1'b0, 8'h04, 8'h01);
        wt(6);
        chk("run", 0, standby_out);
        chk("amp0", 8'h64, current_code_out[0]);
        chk("amp1", 8'h01, current_code_out[1]);
        chk("amp3", 0, current_code_out[3]);
        chk("loop", 4'b0011, loop_member_out);
        measure(49152);
        chk("min on", 96, hi[0]);
        chk("half", 24576, hi[1]);
        chk("zero", 0, hi[2]);
        chk("off", 0, hi[3]);
        // Shortest step: period shrinks with the frequency code
        u_host.set_glob(1'b1, 8'h01, 1'b0, 1'b0, 8'h04, 8'h01);
        wt(4);
        measure(3072);
        chk("fast min", 6, hi[0]);
        chk("fast half", 1536, hi[1]);
        for (int i = 0; i < NUM_CH; i++) u_host.set_ch(i, 1'b1, 1'b0, 8'h20, 11'h400);
        for (int k = 0; k < 3; k++) begin
            u_host.set_glob(1'b1, 8'h10, 1'b1, bj[k][0], 8'h04, bo[k][7:0]);
            wt(10);
            measure(64);
            chk("blink0", b0[k], hi[0]);
            chk("blink3", b3[k], hi[3]);
        end
        u_host.set_glob(1'b1, 8'h10, 1'b0, 1'b0, 8'h04, 8'h01);
        led_open_in[0] = 1'b1;
        wt(10);
        led_open_in[0] = 1'b0;
        wt(10);
        chk("open early", 0, open_fault_out);
        led_open_in[0] = 1'b1;
        wt(30);
        chk("open", 4'b0001, open_fault_out);
        chk("open drive", 0, channel_drive_out[0]);
        led_open_in[0] = 1'b0;
        led_short_in[1] = 1'b1;
        wt(30);
        chk("open gone", 0, open_fault_out);
        chk("short", 4'b0010, short_fault_out);
        led_short_in = 4'hF;
        wt(70);
        chk("all short", 1, all_short_fault_out);
        chk("all drive", 0, channel_drive_out);
        led_short_in = 4'h0;
        u_host.set_ch(0, 1'b0, 1'b0, 8'h20, 11'h400);
        wt(10);
        chk("ch off", 0, channel_drive_out[0]);
        chk("code off", 0, current_code_out[0]);
        // Supply dip: lockout, address recapture, resume on return
        supply_ok_in = 1'b0;
        addr_sense_in = 4'h5;
        wt(6);
        chk("lockout", 0, port_active_out);
        chk("lockout drive", 0, channel_drive_out);
        supply_ok_in = 1'b1;
        wt(8);
        chk("readdr", {TARGET_ADDR_HI_RST, 4'h5}, target_addr_out);
        chk("resume", 4'b1110, channel_drive_out);
        give_verdict();
    end
endmodule
`default_nettype wire
